// ===== bench/sarq_driver_model.sv
/* differential driver plus analog core: samples the input and answers
 * each bit trial.
 * assumes the bench sets diffIn well before the convert pin rises. */
`timescale 1ns/1ps
module sarq_driver_model (
    // clock
    input wire logic               clk,
    // from the bench
    input wire logic signed [19:0] diffIn,     // differential input in lsb
    input wire logic               slowDrive,  // driver settles 8 clocks late
    // converter core
    input sarq_pkg::sarq_analog_t  analog,
    output logic                   compOut,
    output logic                   overRange,
    output logic                   underRange
);
    import sarq_pkg::*;
    logic signed [19:0] pipe [8];     // slow driver settling line
    logic signed [19:0] held = '0;    // charge on the arrays
    logic signed [19:0] clip;         // held value within full scale
    logic [17:0]        offBin;       // offset-binary form of clip
    logic               wobble = 1'b0; // idle comparator is not trusted
    // driver output reaching the pins
    always_ff @(posedge clk) begin
        pipe[0] <= diffIn;
        for (int i = 1; i < 8; i++) begin
            pipe[i] <= pipe[i-1];
        end
        wobble <= ~wobble;
        // arrays only follow the pins while switches are closed
        if (analog.sampleSwitchPos && analog.sampleSwitchNeg && analog.arrayToInput) begin
            held <= slowDrive ? pipe[7] : diffIn;
        end
    end
    // comparator: 1 keeps the trial when charge is not below it
    always_comb begin
        clip = held > 20'sd131071 ? 20'sd131071 : (held < -20'sd131072 ? -20'sd131072 : held);
        offBin = 18'(clip + 20'sd131072);
        compOut = analog.powerUp ? (offBin >= analog.arrayPosRef) : wobble;
        overRange = held > 20'sd131071;
        underRange = held < -20'sd131072;
    end
endmodule

// ===== bench/sarq_sequencer_assertions.sv
/* checker on the sequencer ports.
 * assumes one clock domain; attached by the bind below. */
`timescale 1ns/1ps
module sarq_sequencer_assertions (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // pin and analog core
    input wire logic              convertStartInput,
    input wire logic              compOut,
    input wire logic              overRange,
    input wire logic              underRange,
    input sarq_pkg::sarq_analog_t analog,
    // readout side
    input sarq_pkg::sarq_result_t result
);
    import sarq_pkg::*;
    // ------------------------------------------------------------
    // busy length counter
    // ------------------------------------------------------------
    // open and ground phases, then one conversion clock per element
    localparam int CONV_MIN = 2 * SETTLE_CLKS + NUM_BITS * TRIAL_CLKS;
    localparam int CONV_MAX = CONV_MIN + 2;
    logic [7:0] busyCnt;       // cycles spent busy so far
    logic [7:0] next_busyCnt;
    // restarts at every conversion; a stuck busy is caught by the bound below
    always_comb begin
        next_busyCnt = result.busy ? busyCnt + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busyCnt <= 8'h00;
        end else begin
            busyCnt <= next_busyCnt;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // switch steps at the start of a conversion
    sequence seqOpen;
        !analog.sampleSwitchPos && !analog.sampleSwitchNeg && analog.arrayToInput;
    endsequence
    sequence seqGround;
        !analog.sampleSwitchPos && !analog.arrayToInput && analog.arrayPosRef == 18'h00000;
    endsequence
    chk_open_then_ground: assert property ($rose(result.busy) |-> seqOpen ##[1:4]
        seqGround ##[1:4] analog.arrayPosRef == TRIAL_MSB) else $error("bad switch order");
    chk_acq_tracks: assert property ((!result.busy) [*3] |-> analog.sampleSwitchPos
        && analog.sampleSwitchNeg && analog.arrayToInput && !analog.powerUp)
        else $error("acquisition setting wrong");
    chk_power_busy: assert property (result.busy |-> analog.powerUp)
        else $error("core not powered in conversion");
    chk_neg_mirror: assert property (result.busy && analog.arrayPosRef != 18'h00000
        |-> analog.arrayNegRef == ~analog.arrayPosRef) else $error("arrays not mirrored");
    chk_done_pulse: assert property (result.done |-> ($past(result.busy) && !result.busy)
        ##1 !result.done) else $error("done pulse wrong");
    chk_conv_length: assert property (result.done |-> busyCnt >= CONV_MIN
        && busyCnt <= CONV_MAX) else $error("conversion length wrong");
    chk_conv_bounded: assert property ($rose(result.busy) |->
        ##[CONV_MIN:CONV_MAX] result.done) else $error("conversion did not end");
    chk_start_edge: assert property ($rose(result.busy) |-> $past(convertStartInput, 2))
        else $error("start without convert pin");
    chk_code_hold: assert property ($changed(result.code) |-> result.done)
        else $error("code moved outside done");
    chk_clamp_high: assert property (result.done && overRange && $past(overRange)
        |-> result.code == CODE_POS_FS) else $error("overrange not clamped");
    chk_clamp_low: assert property (result.done && underRange && $past(underRange)
        |-> result.code == CODE_NEG_FS) else $error("underrange not clamped");
endmodule

bind sarq_sequencer sarq_sequencer_assertions sarq_sequencer_assertions_i (
    .clk(clk), .rst_n(rst_n), .convertStartInput(convertStartInput), .compOut(compOut),
    .overRange(overRange), .underRange(underRange), .analog(analog), .result(result));

// ===== bench/tb_top.sv
/* self-checking bench for the sequencer with the driver model.
 * assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module tb_top;
    import sarq_pkg::*;
    logic               clk;
    logic               rst_n;
    logic               convertStartInput;
    logic signed [19:0] diffIn;
    logic               slowDrive;
    logic               compOut;
    logic               overRange;
    logic               underRange;
    sarq_analog_t       analog;
    sarq_result_t       result;
    int                 num_errors;
    int                 total_checks;
    logic signed [19:0] corners [9] = '{0, 1, -1, 131071, 131072, 200000,
                                        -131072, -131071, -200000};

    sarq_sequencer sarq_sequencer_i (.clk(clk), .rst_n(rst_n),
        .convertStartInput(convertStartInput), .compOut(compOut), .overRange(overRange),
        .underRange(underRange), .analog(analog), .result(result));
    sarq_driver_model sarq_driver_model_i (.clk(clk), .diffIn(diffIn),
        .slowDrive(slowDrive), .analog(analog), .compOut(compOut),
        .overRange(overRange), .underRange(underRange));

    always #5 clk = ~clk;

    // two's complement code with both clamps
    function automatic logic [17:0] expect_code(input logic signed [19:0] d);
        if (d > 20'sd131071) return CODE_POS_FS;
        if (d < -20'sd131072) return CODE_NEG_FS;
        return d[17:0];
    endfunction

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one conversion; tog drops and raises the pin again mid-conversion
    task automatic convert(input logic signed [19:0] d, input logic tog, input logic slw);
        logic [17:0] exp;
        int          n;
        exp = expect_code(d);
        @(posedge clk);
        diffIn <= d;
        slowDrive <= slw;
        repeat (12) @(posedge clk);
        convertStartInput <= 1'b1;
        n = 0;
        do begin @(negedge clk); n++; end while (result.busy !== 1'b1 && n < 20);
        check(result.busy, 18'h00001);
        // new input after sampling must not reach this result
        @(posedge clk);
        diffIn <= ~d;
        convertStartInput <= !tog;
        repeat (5) @(posedge clk);
        convertStartInput <= 1'b1;
        n = 0;
        do begin @(negedge clk); n++; end while (result.done !== 1'b1 && n < 200);
        check(result.busy, 18'h00000);
        check(result.code, exp);
        repeat (ACQ_CNT + 10) @(negedge clk);
        check(result.busy, 18'h00000);
        check(result.code, exp);
        @(posedge clk);
        convertStartInput <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // watchdog, well past 21 conversions of about 300 clocks
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        int r;
        clk = 1'b0;
        rst_n = 1'b0;
        convertStartInput = 1'b0;
        diffIn = '0;
        slowDrive = 1'b0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(32'h7926f263));
        repeat (6) @(posedge clk);
        @(negedge clk);
        check(result.code, CODE_RST);
        check({result.done, result.busy, analog.powerUp}, 18'h00000);
        check({analog.sampleSwitchPos, analog.sampleSwitchNeg}, 18'h00003);
        @(posedge clk);
        rst_n <= 1'b1;
        // codes at midscale and at and beyond both ends of the range
        for (int i = 0; i < 9; i++) begin
            convert(corners[i], i[0], i[1]);
        end
        // random inputs inside and a little outside full scale
        repeat (12) begin
            r = int'($urandom_range(280000)) - 140000;
            convert(20'(r), 1'($urandom_range(1)), 1'($urandom_range(1)));
        end
        tally_and_finish();
    end
endmodule

// ===== inc/sarq_pkg.sv
/*
 * package for the sar conversion sequencer: widths, codes, timing counts,
 * state encoding and the packed carriers shared by the sequencer, its
 * analog core and the bench.
 * assumes a 100 MHz system clock and an analog core that presents one
 * comparator decision per trial.
 */
package sarq_pkg;

    // ------------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------------
    localparam int          NUM_BITS     = 18;                 // elements per array
    localparam logic [17:0] CODE_ZERO    = 18'h00000;          // midscale
    localparam logic [17:0] CODE_POS_FS  = 18'h1ffff;          // clamp high
    localparam logic [17:0] CODE_NEG_FS  = 18'h20000;          // clamp low
    localparam logic [17:0] CODE_RST     = 18'h00000;          // result after reset
    localparam logic [17:0] TRIAL_MSB    = 18'h20000;          // first trial weight

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ       = 100;                // system clock rate
    localparam int          RATE_KSPS     = 400;                // highest throughput
    // one full cycle at the top rate, in system clocks (longest time, rounds down)
    localparam int          CYCLE_CLKS    = (CLK_MHZ * 1000) / RATE_KSPS;
    localparam int          SETTLE_NS     = 20;                 // switch settle time
    localparam int          SETTLE_CLKS   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    // conversion clock divide: a trial must outlast the array register (1 clk),
    // the comparator synchroniser (3 clk) and its agree filter (1 clk)
    localparam int          TRIAL_CLKS    = 8;
    localparam logic [7:0]  SETTLE_CNT    = 8'(SETTLE_CLKS);
    localparam logic [7:0]  TRIAL_CNT     = 8'(TRIAL_CLKS);
    // shortest acquisition so a full cycle fits the top rate
    localparam logic [7:0]  ACQ_CNT       = 8'(CYCLE_CLKS - 3 * SETTLE_CLKS
                                            - NUM_BITS * TRIAL_CLKS);

    // ------------------------------------------------------------------
    // states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_ACQ    = 7'h01,   // tracking input, powered down
        ST_OPEN   = 7'h02,   // sample switches opened
        ST_GROUND = 7'h04,   // arrays moved to ground
        ST_TRIAL  = 7'h08,   // bit trials
        ST_FINISH = 7'h10,   // code out, back to acquisition
        ST_IDLE   = 7'h20,   // acquisition done, awaiting edge
        ST_RSVD   = 7'h40    // unused code
    } sarq_state_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        sampleSwitchPos;   // closed = 1
        logic        sampleSwitchNeg;   // closed = 1
        logic        arrayToInput;      // bottom plates on inputs
        logic [17:0] arrayPosRef;       // per element: 1 = ref, 0 = ground
        logic [17:0] arrayNegRef;
        logic        powerUp;           // comparator and bias active
    } sarq_analog_t;

    typedef struct packed {
        logic [17:0] code;     // two's complement result
        logic        done;     // one-cycle end-of-conversion pulse
        logic        busy;     // conversion in progress
    } sarq_result_t;

endpackage

// ===== src/sarq_sequencer.sv
/*
 * conversion sequencer of an 18-bit charge-redistribution converter:
 * acquisition, sample switch control, bit trials on an internal conversion
 * clock, offset-binary to two's complement coding, clamping and done/busy.
 * assumes the convert input is an asynchronous pin, the comparator output
 * is asynchronous to clk, and the overrange flags come from the analog core.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - acquisition grounds top plates, bottoms track inputs
// - convert rising edge after acquisition starts conversion
// - open sample switches, then ground arrays
// - two 18-element binary arrays, successive approximation
// - msb first, keep or release each trial
// - last trial: acquire, output code, done pulse
// - up to 400 kSPS, powered down between conversions
// - result belongs to the sample just converted
// - internal conversion clock times trials
// - two's complement output code
// - overrange saturates at 0x1ffff
// - underrange saturates at 0x20000
// - convert edges ignored while converting
module sarq_sequencer (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // convert pin from the outside party
    input  wire logic                 convertStartInput,
    // analog core
    input  wire logic                 compOut,      // 1 = positive side higher
    input  wire logic                 overRange,    // input above full scale
    input  wire logic                 underRange,   // input below negative full scale
    output sarq_pkg::sarq_analog_t    analog,
    // readout side
    output sarq_pkg::sarq_result_t    result
);
    import sarq_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0]  cnvSync;      // [0] first stage, read only by [1]
    logic [2:0]  next_cnvSync;
    logic        cnvLevel;     // filtered level
    logic        next_cnvLevel;
    logic [2:0]  cmpSync;
    logic [2:0]  next_cmpSync;
    logic        cmpLevel;
    logic        next_cmpLevel;
    logic        cnvRise;

    // a change counts only when the second and third stages agree
    always_comb begin
        next_cnvSync  = {cnvSync[1:0], convertStartInput};
        next_cmpSync  = {cmpSync[1:0], compOut};
        next_cnvLevel = (cnvSync[1] == cnvSync[2]) ? cnvSync[2] : cnvLevel;
        next_cmpLevel = (cmpSync[1] == cmpSync[2]) ? cmpSync[2] : cmpLevel;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnvSync  <= 3'h0;
            cmpSync  <= 3'h0;
            cnvLevel <= 1'b0;
            cmpLevel <= 1'b0;
        end else begin
            cnvSync  <= next_cnvSync;
            cmpSync  <= next_cmpSync;
            cnvLevel <= next_cnvLevel;
            cmpLevel <= next_cmpLevel;
        end
    end

    // rising edge of the filtered convert level
    assign cnvRise = next_cnvLevel & ~cnvLevel;

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    sarq_state_t state;          // current phase
    sarq_state_t next_state;
    logic [7:0]  timer;          // phase and conversion-clock counter
    logic [7:0]  next_timer;
    logic        trialStart;     // load msb trial
    logic        trialStep;      // conversion clock tick: resolve a bit
    logic [17:0] trialBits;
    logic        lastBit;

    // a tick of the internal conversion clock, derived from clk only
    function automatic logic expired(input logic [7:0] t);
        return (t == 8'h01);
    endfunction

    // phase transitions; the convert pin is looked at only in ST_IDLE
    always_comb begin
        next_state = state;
        next_timer = (timer != 8'h00) ? timer - 8'h01 : 8'h00;
        trialStart = 1'b0;
        trialStep  = 1'b0;
        case (state)
            ST_ACQ: begin
                // acquisition must run its minimum before an edge is taken
                if (expired(timer)) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cnvRise) begin
                    next_state = ST_OPEN;
                    next_timer = SETTLE_CNT;
                end
            end
            ST_OPEN: begin
                // switches open first, arrays stay on the inputs
                if (expired(timer)) begin
                    next_state = ST_GROUND;
                    next_timer = SETTLE_CNT;
                end
            end
            ST_GROUND: begin
                if (expired(timer)) begin
                    next_state = ST_TRIAL;
                    next_timer = TRIAL_CNT;
                    trialStart = 1'b1;
                end
            end
            ST_TRIAL: begin
                // each tick of the divided conversion clock decides one bit
                if (expired(timer)) begin
                    trialStep  = 1'b1;
                    next_timer = TRIAL_CNT;
                    if (lastBit) begin
                        next_state = ST_FINISH;
                        next_timer = SETTLE_CNT;
                    end
                end
            end
            ST_FINISH: begin
                next_state = ST_ACQ;
                next_timer = ACQ_CNT;
            end
            default: begin
                next_state = ST_ACQ;
                next_timer = ACQ_CNT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_ACQ;
            timer <= 8'h01;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // ------------------------------------------------------------------
    // bit-trial register
    // ------------------------------------------------------------------
    sarq_trial_reg u_trial (
        .clk       (clk),
        .rst_n     (rst_n),
        .start     (trialStart),
        .step      (trialStep),
        .compHigh  (~cmpLevel),
        .trialBits (trialBits),
        .lastBit   (lastBit)
    );

    // ------------------------------------------------------------------
    // switch drive
    // ------------------------------------------------------------------
    sarq_analog_t next_analog;
    logic         inConv;

    assign inConv = (state == ST_OPEN) || (state == ST_GROUND) || (state == ST_TRIAL);

    // positive array adds the trial, negative array its complement, so
    // both arrays share 18 elements stepping half ref to ref/262144
    always_comb begin
        next_analog                 = '0;
        next_analog.sampleSwitchPos = ~inConv & (next_state != ST_OPEN);
        next_analog.sampleSwitchNeg = ~inConv & (next_state != ST_OPEN);
        next_analog.arrayToInput    = (next_state == ST_ACQ)
                                    || (next_state == ST_IDLE)
                                    || (next_state == ST_OPEN);
        // on the entry edge the trial register still holds the last result,
        // so the arrays stay grounded one more clock instead of showing it
        if ((state == ST_TRIAL) && (next_state == ST_TRIAL)) begin
            next_analog.arrayPosRef = trialBits;
            next_analog.arrayNegRef = ~trialBits;
        end
        // bias is off outside conversion, so power tracks the rate
        next_analog.powerUp = (next_state == ST_OPEN)
                            || (next_state == ST_GROUND)
                            || (next_state == ST_TRIAL);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog <= '{sampleSwitchPos: 1'b1, sampleSwitchNeg: 1'b1,
                        arrayToInput: 1'b1, arrayPosRef: 18'h00000,
                        arrayNegRef: 18'h00000, powerUp: 1'b0};
        end else begin
            analog <= next_analog;
        end
    end

    // ------------------------------------------------------------------
    // output code
    // ------------------------------------------------------------------
    sarq_result_t next_result;
    logic [17:0]  finalBits;

    // the lsb decision is folded in on the same step that ends the trials
    assign finalBits = cmpLevel ? trialBits : (trialBits & ~18'h00001);

    // offset binary to two's complement is a flip of the msb
    function automatic logic [17:0] to_twos(input logic [17:0] ob);
        return {~ob[17], ob[16:0]};
    endfunction

    always_comb begin
        next_result      = result;
        next_result.done = 1'b0;
        next_result.busy = (next_state == ST_OPEN) || (next_state == ST_GROUND)
                         || (next_state == ST_TRIAL);
        // code updates only when this very sample finishes, no pipeline
        if (trialStep && lastBit) begin
            next_result.done = 1'b1;
            if (overRange) begin
                next_result.code = CODE_POS_FS;
            end else if (underRange) begin
                next_result.code = CODE_NEG_FS;
            end else begin
                next_result.code = to_twos(finalBits);
            end
        end
        // otherwise the held code stands for the readout port
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= '{code: CODE_RST, done: 1'b0, busy: 1'b0};
        end else begin
            result <= next_result;
        end
    end

    // convert edges outside ST_IDLE fall through the case above

endmodule

// ===== src/sarq_trial_reg.sv
/*
 * successive-approximation register: holds the trial mask and the
 * decided bits, moves one weight down per step.
 * assumes the sequencer gives start, step and the comparator decision on
 * the same clock.
 */
`timescale 1ns/1ps
module sarq_trial_reg (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        start,      // load msb trial
    input  wire logic        step,       // resolve current bit
    input  wire logic        compHigh,   // 1 = trial overshot, release it
    // state
    output logic [17:0]      trialBits,  // bits driven to the array now
    output logic             lastBit     // current trial is the lsb
);
    import sarq_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [17:0] mask;          // weight under trial
    logic [17:0] next_mask;
    logic [17:0] next_trialBits;

    // next trial: keep or drop the bit, then add the next weight
    always_comb begin
        next_mask      = mask;
        next_trialBits = trialBits;
        if (start) begin
            next_mask      = TRIAL_MSB;
            next_trialBits = TRIAL_MSB;
        end else if (step) begin
            next_mask      = mask >> 1;
            // release on overshoot, so the comparator walks back to balance
            next_trialBits = (compHigh ? (trialBits & ~mask) : trialBits)
                           | (mask >> 1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask      <= 18'h00000;
            trialBits <= 18'h00000;
        end else begin
            mask      <= next_mask;
            trialBits <= next_trialBits;
        end
    end

    assign lastBit = mask[0];

endmodule
